/* common/vram_host_pkg.sv */
package vram_host_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int PHASE_NS = 100;
  localparam int PHASE_CYCLES = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_COUNT = 512;
  localparam int REFRESH_INTERVAL_DEFAULT = 300;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ROW = 8'h04;
  localparam logic [7:0] REG_COL = 8'h08;
  localparam logic [7:0] REG_WDATA = 8'h0C;
  localparam logic [7:0] REG_MASK = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_REFCTL = 8'h1C;

  // ==========================================================
  // Command, status and refresh control register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_LATE_BIT = 4;
  localparam int CMD_MASKED_BIT = 5;
  localparam int CMD_LANE_LSB = 6;
  localparam int CMD_KIND_LSB = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_COLOR_BIT = 1;
  localparam int STAT_PERSIST_BIT = 2;
  localparam int STAT_ERROR_BIT = 3;
  localparam int STAT_PENDING_BIT = 4;
  localparam int REFCTL_EN_BIT = 0;
  localparam int REFCTL_KIND_LSB = 1;
  localparam logic [1:0] REFCTL_RESET = 2'h0;

  // ==========================================================
  // Operation codes
  localparam logic [3:0] OP_READ = 4'h0;
  localparam logic [3:0] OP_WRITE = 4'h1;
  localparam logic [3:0] OP_BLOCK = 4'h2;
  localparam logic [3:0] OP_LOAD_MASK = 4'h3;
  localparam logic [3:0] OP_LOAD_COLOR = 4'h4;
  localparam logic [3:0] OP_CBR = 4'h5;
  localparam logic [3:0] OP_RAS_ONLY = 4'h6;
  localparam logic [3:0] OP_HIDDEN = 4'h7;

  localparam logic [1:0] KIND_OPTION_RESET = 2'h0;
  localparam logic [1:0] KIND_NO_RESET = 2'h1;
  localparam logic [1:0] KIND_STOP_POINT = 2'h2;
  localparam logic [1:0] KIND_RESERVED = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE, ST_PRE_RAS, ST_RAS, ST_COL, ST_CAS, ST_LATE_WE,
    ST_HID_HIGH, ST_HID_LOW, ST_RELEASE
  } state_type;

  typedef struct packed {
    logic [3:0] op;
    logic late;
    logic masked;
    logic [1:0] lanes;
    logic [1:0] kind;
    logic [8:0] row;
    logic [8:0] col;
    logic [15:0] data;
    logic [15:0] mask;
  } cmd_type;

  typedef struct packed {
    logic ras_n;
    logic lower_column_strobe_n_n;
    logic upper_column_strobe_n_n;
    logic we_n;
    logic trg_n;
    logic special_function_select;
    logic [8:0] addr;
    logic [15:0] dq;
    logic dq_oe;
  } pins_type;

  localparam pins_type PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0,
                                      9'h000, 16'h0000, 1'b0};

endpackage

/* verilog/vram_host.sv */
// What this block does
// - Column strobes fall before row strobe to start a refresh, row internal.
// - Controller refreshes all 512 rows within the refresh period.
// - Hidden refresh holds both column strobes low after read, recycles row.
// - Row-only refresh strobes each external row address with row strobe.
// - Early write drops write strobe before both column strobes fall.
// - Late write drops write strobe after a column strobe has fallen.
// - Load mask: select high at row fall, low at column fall.
// - Block write: select high at column fall, column mask on data pins.
// - Color register must be loaded before any block write.
// - Output-enable/transfer select held high at row fall for DRAM cycles.
`timescale 1ns/1ns
`default_nettype none
module vram_host
  import vram_host_pkg::*;
#(
  parameter int REFRESH_INTERVAL = REFRESH_INTERVAL_DEFAULT
) (
  input wire logic sys_clk_in, // System clock
  input wire logic rst_n_in, // Async reset, low
  input wire logic [7:0] addr_in, // Register address
  input wire logic [31:0] wdata_in, // Register write data
  input wire logic wr_in, // Write strobe
  input wire logic rd_in, // Read strobe
  output logic [31:0] rdata_out, // Read data, cycle after strobe
  output logic ras_n_out, // Row strobe
  output logic lower_column_strobe_n_out, // Lower byte column strobe
  output logic upper_column_strobe_n_out, // Upper byte column strobe
  output logic we_n_out, // Write strobe
  output logic output_enable_transfer_select_n_out, // Output enable
  output logic special_function_select_out, // Special function
  output logic [8:0] multiplexed_address_out, // Row/column address
  input wire logic [15:0] random_data_pins_in, // Data pins in
  output logic [15:0] random_data_pins_out, // Data pins out
  output logic random_data_pins_oe_out // High while driving data
);

  // ==========================================================
  // Reset release
  logic rst_meta;
  logic rst_sync;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ==========================================================
  // Helpers
  function automatic logic is_write_op(input logic [3:0] op);
    return op == OP_WRITE || op == OP_BLOCK || op == OP_LOAD_MASK ||
           op == OP_LOAD_COLOR;
  endfunction

  function automatic logic is_refresh_op(input logic [3:0] op);
    return op == OP_CBR || op == OP_RAS_ONLY;
  endfunction

  // ==========================================================
  // Sequencer and software registers
  state_type state, next_state;
  cmd_type cur, next_cur;
  logic [3:0] timer, next_timer;
  pins_type pins, next_pins;
  logic [8:0] row_reg, next_row_reg;
  logic [8:0] col_reg, next_col_reg;
  logic [15:0] wdata_reg, next_wdata_reg;
  logic [15:0] mask_reg, next_mask_reg;
  logic [15:0] read_data, next_read_data;
  logic [2:0] refctl, next_refctl;
  logic color_loaded, next_color_loaded;
  logic persistent, next_persistent;
  logic error, next_error;
  logic ref_pending, next_ref_pending;
  logic [31:0] ref_count, next_ref_count;
  logic [31:0] rdata, next_rdata;
  logic step;
  logic cmd_write;
  cmd_type sw_cmd;

  assign step = (timer == 4'h0);
  assign cmd_write = wr_in && addr_in == REG_CMD;

  always_comb begin
    sw_cmd.op = wdata_in[CMD_OP_LSB +: 4];
    sw_cmd.late = wdata_in[CMD_LATE_BIT];
    sw_cmd.masked = wdata_in[CMD_MASKED_BIT];
    sw_cmd.lanes = wdata_in[CMD_LANE_LSB +: 2];
    sw_cmd.kind = wdata_in[CMD_KIND_LSB +: 2];
    sw_cmd.row = row_reg;
    sw_cmd.col = col_reg;
    sw_cmd.data = wdata_reg;
    sw_cmd.mask = mask_reg;
  end

  always_comb begin
    next_state = state;
    next_cur = cur;
    next_timer = step ? 4'h0 : timer - 4'h1;
    next_row_reg = row_reg;
    next_col_reg = col_reg;
    next_wdata_reg = wdata_reg;
    next_mask_reg = mask_reg;
    next_read_data = read_data;
    next_refctl = refctl;
    next_color_loaded = color_loaded;
    next_persistent = persistent;
    next_error = error;
    next_ref_pending = ref_pending;
    next_ref_count = ref_count + 32'h1;
    next_rdata = 32'h0;
    if (ref_count >= 32'(REFRESH_INTERVAL - 1) && refctl[REFCTL_EN_BIT]) begin
      next_ref_count = 32'h0;
    end else if (!refctl[REFCTL_EN_BIT]) begin
      next_ref_count = 32'h0;
    end
    // Software writes
    if (wr_in) begin
      case (addr_in)
        REG_ROW: next_row_reg = wdata_in[8:0];
        REG_COL: next_col_reg = wdata_in[8:0];
        REG_WDATA: next_wdata_reg = wdata_in[15:0];
        REG_MASK: next_mask_reg = wdata_in[15:0];
        REG_REFCTL: next_refctl = wdata_in[2:0];
        REG_STATUS: begin
          if (wdata_in[STAT_ERROR_BIT]) begin
            next_error = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (rd_in) begin
      case (addr_in)
        REG_ROW: next_rdata = {23'h0, row_reg};
        REG_COL: next_rdata = {23'h0, col_reg};
        REG_WDATA: next_rdata = {16'h0, wdata_reg};
        REG_MASK: next_rdata = {16'h0, mask_reg};
        REG_RDATA: next_rdata = {16'h0, read_data};
        REG_REFCTL: next_rdata = {29'h0, refctl};
        REG_STATUS: next_rdata = {27'h0, ref_pending, error, persistent,
                                  color_loaded, state != ST_IDLE};
        default: next_rdata = 32'h0;
      endcase
    end
    // Spread refreshes evenly so every row is reached in time
    if (refctl[REFCTL_EN_BIT] && ref_count >= 32'(REFRESH_INTERVAL - 1)) begin
      next_ref_pending = 1'b1;
    end
    case (state)
      ST_IDLE: begin
        if (cmd_write) begin
          // Busy is not possible here; refuse only illegal orders
          if ((sw_cmd.op == OP_BLOCK && !color_loaded) ||
              (sw_cmd.op == OP_CBR && sw_cmd.kind == KIND_RESERVED) ||
              sw_cmd.op > OP_HIDDEN) begin
            next_error = 1'b1;
          end else begin
            next_cur = sw_cmd;
            next_state = ST_PRE_RAS;
            next_timer = 4'(PHASE_CYCLES - 1);
          end
        end else if (ref_pending) begin
          next_ref_pending = 1'b0;
          next_cur = sw_cmd;
          next_cur.op = OP_CBR;
          next_cur.kind = refctl[REFCTL_KIND_LSB +: 2] == KIND_RESERVED ?
                          KIND_NO_RESET : refctl[REFCTL_KIND_LSB +: 2];
          next_state = ST_PRE_RAS;
          next_timer = 4'(PHASE_CYCLES - 1);
        end
      end
      ST_PRE_RAS: if (step) begin
        next_state = ST_RAS;
        next_timer = 4'(PHASE_CYCLES - 1);
      end
      ST_RAS: if (step) begin
        next_state = is_refresh_op(cur.op) ? ST_RELEASE : ST_COL;
        next_timer = 4'(PHASE_CYCLES - 1);
      end
      ST_COL: if (step) begin
        next_state = ST_CAS;
        next_timer = 4'(PHASE_CYCLES - 1);
      end
      ST_CAS: if (step) begin
        if (cur.op == OP_READ || cur.op == OP_HIDDEN) begin
          next_read_data = random_data_pins_in;
        end
        if (cur.late && is_write_op(cur.op)) begin
          next_state = ST_LATE_WE;
        end else if (cur.op == OP_HIDDEN) begin
          next_state = ST_HID_HIGH;
        end else begin
          next_state = ST_RELEASE;
        end
        next_timer = 4'(PHASE_CYCLES - 1);
      end
      ST_LATE_WE: if (step) begin
        next_state = ST_RELEASE;
        next_timer = 4'(PHASE_CYCLES - 1);
      end
      ST_HID_HIGH: if (step) begin
        next_state = ST_HID_LOW;
        next_timer = 4'(PHASE_CYCLES - 1);
      end
      ST_HID_LOW: if (step) begin
        next_state = ST_RELEASE;
        next_timer = 4'(PHASE_CYCLES - 1);
      end
      ST_RELEASE: if (step) begin
        next_state = ST_IDLE;
        // Mirror of the device's mask mode
        if (cur.op == OP_LOAD_MASK) begin
          next_persistent = 1'b1;
        end else if (cur.op == OP_HIDDEN ||
                     (cur.op == OP_CBR && cur.kind == KIND_OPTION_RESET)) begin
          // Hidden row fall has write high, select low: option reset
          next_persistent = 1'b0;
        end
        if (cur.op == OP_LOAD_COLOR) begin
          next_color_loaded = 1'b1;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // Command while busy is dropped and flagged; set beats clear
    if (cmd_write && state != ST_IDLE) begin
      next_error = 1'b1;
    end
  end

  // ==========================================================
  // Pin levels for each phase
  always_comb begin
    next_pins = PINS_IDLE;
    next_pins.addr = next_cur.row;
    case (next_state)
      ST_PRE_RAS, ST_RAS: begin
        next_pins.ras_n = (next_state != ST_RAS);
        next_pins.trg_n = 1'b1;
        if (next_cur.op == OP_CBR) begin
          // Strobes low a phase before row strobe falls
          next_pins.lower_column_strobe_n_n = 1'b0;
          next_pins.upper_column_strobe_n_n = 1'b0;
          next_pins.we_n = next_cur.kind != KIND_STOP_POINT;
          next_pins.special_function_select = next_cur.kind != KIND_OPTION_RESET;
        end else begin
          // Masked write: write strobe low with mask on pins
          next_pins.we_n = !(next_cur.masked &&
                             (next_cur.op == OP_WRITE ||
                              next_cur.op == OP_BLOCK));
          next_pins.special_function_select = next_cur.op == OP_LOAD_MASK ||
                          next_cur.op == OP_LOAD_COLOR;
          next_pins.dq = next_cur.mask;
          next_pins.dq_oe = !next_pins.we_n;
        end
      end
      ST_COL, ST_CAS, ST_LATE_WE: begin
        next_pins.ras_n = 1'b0;
        next_pins.addr = next_cur.col; // One column per row cycle: row stays open
        next_pins.special_function_select = next_cur.op == OP_BLOCK ||
                        next_cur.op == OP_LOAD_COLOR;
        next_pins.we_n = !(is_write_op(next_cur.op) &&
                           (!next_cur.late || next_state == ST_LATE_WE ||
                            next_pins.we_n == 1'b0));
        next_pins.dq = next_cur.data; // Column mask for block write
        next_pins.dq_oe = is_write_op(next_cur.op);
        if (next_state != ST_COL) begin
          if (next_cur.op == OP_HIDDEN) begin
            next_pins.lower_column_strobe_n_n = 1'b0;
            next_pins.upper_column_strobe_n_n = 1'b0;
          end else begin
            next_pins.lower_column_strobe_n_n = !next_cur.lanes[0];
            next_pins.upper_column_strobe_n_n = !next_cur.lanes[1];
          end
          next_pins.trg_n = !(next_cur.op == OP_READ ||
                              next_cur.op == OP_HIDDEN);
        end
      end
      ST_HID_HIGH, ST_HID_LOW: begin
        // Column strobes and output enable held so read data stays
        next_pins.ras_n = (next_state == ST_HID_HIGH);
        next_pins.lower_column_strobe_n_n = 1'b0;
        next_pins.upper_column_strobe_n_n = 1'b0;
        next_pins.trg_n = 1'b0;
      end
      default: ;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      state <= ST_IDLE;
      cur <= '0;
      timer <= 4'h0;
      pins <= PINS_IDLE;
      row_reg <= 9'h000;
      col_reg <= 9'h000;
      wdata_reg <= 16'h0000;
      mask_reg <= 16'h0000;
      read_data <= 16'h0000;
      refctl <= {REFCTL_RESET, 1'b0};
      color_loaded <= 1'b0;
      persistent <= 1'b0;
      error <= 1'b0;
      ref_pending <= 1'b0;
      ref_count <= 32'h0;
      rdata <= 32'h0;
    end else begin
      state <= next_state;
      cur <= next_cur;
      timer <= next_timer;
      pins <= next_pins;
      row_reg <= next_row_reg;
      col_reg <= next_col_reg;
      wdata_reg <= next_wdata_reg;
      mask_reg <= next_mask_reg;
      read_data <= next_read_data;
      refctl <= next_refctl;
      color_loaded <= next_color_loaded;
      persistent <= next_persistent;
      error <= next_error;
      ref_pending <= next_ref_pending;
      ref_count <= next_ref_count;
      rdata <= next_rdata;
    end
  end

  assign rdata_out = rdata;
  assign ras_n_out = pins.ras_n;
  assign lower_column_strobe_n_out = pins.lower_column_strobe_n_n;
  assign upper_column_strobe_n_out = pins.upper_column_strobe_n_n;
  assign we_n_out = pins.we_n;
  assign output_enable_transfer_select_n_out = pins.trg_n;
  assign special_function_select_out = pins.special_function_select;
  assign multiplexed_address_out = pins.addr;
  assign random_data_pins_out = pins.dq;
  assign random_data_pins_oe_out = pins.dq_oe;

  // ==========================================================
  // Checks
  // Previous strobe levels, so first column fall is plain logic
  logic cas_fell;
  logic lower_column_strobe_n_q;
  logic upper_column_strobe_n_q;
  always_ff @(posedge sys_clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      lower_column_strobe_n_q <= 1'b1;
      upper_column_strobe_n_q <= 1'b1;
    end else begin
      lower_column_strobe_n_q <= pins.lower_column_strobe_n_n;
      upper_column_strobe_n_q <= pins.upper_column_strobe_n_n;
    end
  end
  assign cas_fell = lower_column_strobe_n_q && upper_column_strobe_n_q && !(pins.lower_column_strobe_n_n && pins.upper_column_strobe_n_n);

  sequence both_cas_low_s;
    !pins.lower_column_strobe_n_n && !pins.upper_column_strobe_n_n;
  endsequence

  sequence ras_recycle_s;
    $rose(pins.ras_n) ##1 pins.ras_n [*1];
  endsequence

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_sync);

  trg_at_ras_a: assert property (
    $fell(pins.ras_n) && pins.lower_column_strobe_n_n && pins.upper_column_strobe_n_n |-> pins.trg_n)
    else $error("output enable low at row strobe fall");
  cbr_order_a: assert property (
    $fell(pins.ras_n) && cur.op == OP_CBR |->
      $past(!pins.lower_column_strobe_n_n, PHASE_CYCLES) && $past(!pins.upper_column_strobe_n_n, PHASE_CYCLES))
    else $error("column strobes not low before refresh row strobe");
  early_write_a: assert property (
    cas_fell && is_write_op(cur.op) && !cur.late |-> !pins.we_n)
    else $error("early write strobe not low at column fall");
  late_write_a: assert property (
    $fell(pins.we_n) && !pins.ras_n |->
      (cur.late ? (!pins.lower_column_strobe_n_n || !pins.upper_column_strobe_n_n) :
                  (pins.lower_column_strobe_n_n && pins.upper_column_strobe_n_n)))
    else $error("write strobe fell on the wrong side of column strobe");
  load_mask_dsf_a: assert property (
    $fell(pins.ras_n) && cur.op == OP_LOAD_MASK |->
      pins.special_function_select ##(2 * PHASE_CYCLES) !pins.special_function_select && cas_fell)
    else $error("load mask select levels wrong");
  block_dsf_a: assert property (
    cas_fell && cur.op == OP_BLOCK |-> pins.special_function_select && pins.dq_oe &&
      pins.dq == cur.data)
    else $error("block write select or column mask wrong");
  block_color_a: assert property (
    $fell(pins.ras_n) && cur.op == OP_BLOCK |-> color_loaded)
    else $error("block write before color load");
  hidden_hold_a: assert property (
    state == ST_HID_HIGH && $rose(pins.ras_n) |->
      both_cas_low_s and ras_recycle_s)
    else $error("hidden refresh released column strobes");
  ras_only_a: assert property (
    $fell(pins.ras_n) && cur.op == OP_RAS_ONLY |->
      pins.lower_column_strobe_n_n && pins.upper_column_strobe_n_n && pins.addr == cur.row)
    else $error("row-only refresh address or strobes wrong");
  refresh_gap_a: assert property (
    refctl[REFCTL_EN_BIT] |-> ref_count < 32'(REFRESH_INTERVAL))
    else $error("refresh interval overrun");

endmodule
`default_nettype wire

/* tb/vram_device_model.sv */
`timescale 1ns/1ns
`default_nettype none
module vram_device_model (
  input wire logic ras_n_in, // Row strobe
  input wire logic lower_column_strobe_n_in, // Lower byte strobe
  input wire logic upper_column_strobe_n_in, // Upper byte strobe
  input wire logic we_n_in, // Write strobe
  input wire logic output_enable_transfer_select_n_in, // Output enable
  input wire logic special_function_select_in, // Function select
  input wire logic [8:0] multiplexed_address_in, // Row/column address
  input wire logic [15:0] random_data_pins_in, // Resolved data wire
  output logic [15:0] random_data_pins_out // Data driven by device
);
  bit [15:0] mem [0:262143];
  logic [15:0] pmask = 16'hFFFF, eff = 16'hFFFF, color = 16'h0000;
  logic [15:0] rword = 16'h0000, en;
  logic [8:0] row, col, ref_row = 9'h000, ras_row = 9'h000, stop_code;
  logic persist = 0, stop_mode = 0, refr = 0, hid = 0, dsf_r, dsf_c;
  logic got_col = 0, done = 0;
  int bad_oe = 0;
  wire logic col_n = lower_column_strobe_n_in & upper_column_strobe_n_in;
  wire logic oe_n = output_enable_transfer_select_n_in;
  wire logic quiet = refr && !hid;
  wire logic lo_on = !lower_column_strobe_n_in && !oe_n && !quiet;
  wire logic hi_on = !upper_column_strobe_n_in && !oe_n && !quiet;
  // Released lanes show the inverse, never a stale copy
  assign random_data_pins_out = {hi_on ? rword[15:8] : ~rword[15:8],
    lo_on ? rword[7:0] : ~rword[7:0]};

  task automatic commit();
    en = {{8{!upper_column_strobe_n_in}}, {8{!lower_column_strobe_n_in}}};
    if (dsf_r && !dsf_c) begin
      pmask = (pmask & ~en) | (random_data_pins_in & en);
      persist = 1;
    end else if (dsf_r) begin
      color = (color & ~en) | (random_data_pins_in & en);
    end else if (dsf_c) begin
      for (int c = 0; c < 4; c++)
        for (int b = 0; b < 16; b++)
          if (random_data_pins_in[(b / 4) * 4 + c] && eff[b] && en[b])
            mem[{row, col[8:2], c[1:0]}][b] = color[b];
    end else begin
      en = en & eff;
      mem[{row, col}] = (mem[{row, col}] & ~en) | (random_data_pins_in & en);
    end
  endtask

  always @(negedge ras_n_in) begin
    refr = !col_n;
    hid = refr && !oe_n;
    got_col = 0;
    done = 0;
    if (refr) begin
      ref_row = ref_row + 9'h001;
      if (we_n_in && !special_function_select_in) begin
        persist = 0;
        stop_mode = 0;
      end else if (!we_n_in && special_function_select_in) begin
        stop_mode = 1;
        stop_code = multiplexed_address_in;
      end
    end else begin
      if (!oe_n) bad_oe++;
      row = multiplexed_address_in;
      ras_row = row;
      dsf_r = special_function_select_in;
      eff = we_n_in ? 16'hFFFF : (persist ? pmask : random_data_pins_in);
    end
  end

  always @(negedge col_n or negedge we_n_in) begin
    if (!ras_n_in && !refr && !col_n) begin
      if (!got_col) begin
        got_col = 1;
        col = multiplexed_address_in;
        dsf_c = special_function_select_in;
        rword = mem[{row, col}];
      end
      if (!we_n_in && !done) begin
        done = 1;
        commit();
      end
    end
  end
endmodule
`default_nettype wire

/* tb/vram_host_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module vram_host_tb
  import vram_host_pkg::*;
;
  logic sys_clk_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0, rdata_out;
  logic ras_n, lower_column_strobe_n_n, upper_column_strobe_n_n, we_n, oe_n, sel, dq_oe;
  logic [8:0] maddr, r0;
  logic [15:0] dq_out, dev_dq, d1, d2, cur, rnd = 16'h0009;
  wire logic [15:0] dq_wire = dq_oe ? dq_out : dev_dq;
  logic [31:0] exp_q[$];
  bit note_q[$];
  logic rd_seen = 1'b0;
  logic [1:0] kinds [3] = '{KIND_NO_RESET, KIND_STOP_POINT, KIND_OPTION_RESET};
  int n_errors = 0, cmp_count = 0;
  always #25 sys_clk_in = ~sys_clk_in;

  vram_host #(.REFRESH_INTERVAL(40)) u_dut (.sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .ras_n_out(ras_n), .lower_column_strobe_n_out(lower_column_strobe_n_n),
    .upper_column_strobe_n_out(upper_column_strobe_n_n), .we_n_out(we_n),
    .output_enable_transfer_select_n_out(oe_n),
    .special_function_select_out(sel), .multiplexed_address_out(maddr),
    .random_data_pins_in(dq_wire), .random_data_pins_out(dq_out),
    .random_data_pins_oe_out(dq_oe));
  vram_device_model u_dev (.ras_n_in(ras_n),
    .lower_column_strobe_n_in(lower_column_strobe_n_n), .upper_column_strobe_n_in(upper_column_strobe_n_n),
    .we_n_in(we_n), .output_enable_transfer_select_n_in(oe_n),
    .special_function_select_in(sel), .multiplexed_address_in(maddr),
    .random_data_pins_in(dq_wire), .random_data_pins_out(dev_dq));

  // ==========================================================
  // Shared tasks
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input bit n);
    note_q.push_back(n);
    if (n) exp_q.push_back(e);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
  endtask
  // Results compared in a separate watcher, oldest note first
  always @(posedge sys_clk_in) rd_seen <= rd_in;
  always @(negedge sys_clk_in) begin
    if (rd_seen && note_q.pop_front()) chk(rdata_out, exp_q.pop_front());
  end
  task automatic wait_idle();
    for (int i = 0; i < 40; i++) begin
      rd(REG_STATUS, 32'h0, 1'b0);
      @(negedge sys_clk_in);
      if (rdata_out[STAT_BUSY_BIT] === 1'b0) return;
    end
    n_errors++;
    $display("[ERR] %0t stuck busy", $time);
  endtask
  task automatic op(input logic [3:0] o, input logic [1:0] ln,
    input logic lt, input logic ms, input logic [1:0] k);
    wr(REG_CMD, {22'h0, k, ln, ms, lt, o});
    wait_idle();
  endtask
  task automatic setup(input logic [8:0] r, input logic [8:0] c,
    input logic [15:0] d, input logic [15:0] m);
    wr(REG_ROW, {23'h0, r});
    wr(REG_COL, {23'h0, c});
    wr(REG_WDATA, {16'h0, d});
    wr(REG_MASK, {16'h0, m});
  endtask
  task automatic stop_test();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_in);
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test();
  end

  // ==========================================================
  // Scenarios
  initial begin
    repeat (2) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    rd(REG_STATUS, 32'h0, 1);
    rd(8'hFC, 32'h0, 1);
    rnd = lfsr(rnd);
    d1 = rnd;
    setup(9'h005, 9'h003, d1, 16'hFFFF);
    op(OP_WRITE, 2'h3, 0, 0, 2'h0);
    chk(u_dev.mem[{9'h005, 9'h003}], {16'h0, d1});
    op(OP_READ, 2'h3, 0, 0, 2'h0);
    rd(REG_RDATA, {16'h0, d1}, 1);
    rnd = lfsr(rnd);
    d2 = rnd;
    setup(9'h005, 9'h003, d2, 16'hFFFF);
    op(OP_WRITE, 2'h2, 1, 0, 2'h0);
    cur = {d2[15:8], d1[7:0]};
    chk(u_dev.mem[{9'h005, 9'h003}], {16'h0, cur});
    setup(9'h005, 9'h003, ~cur, 16'h00FF);
    op(OP_WRITE, 2'h3, 0, 1, 2'h0);
    cur = {cur[15:8], ~cur[7:0]};
    chk(u_dev.mem[{9'h005, 9'h003}], {16'h0, cur});
    setup(9'h005, 9'h003, 16'h0F0F, 16'hFFFF);
    op(OP_LOAD_MASK, 2'h3, 0, 0, 2'h0);
    rd(REG_STATUS, 32'h4, 1);
    setup(9'h005, 9'h003, 16'h0000, 16'hFFFF);
    op(OP_WRITE, 2'h3, 0, 1, 2'h0);
    cur = cur & 16'hF0F0;
    chk(u_dev.mem[{9'h005, 9'h003}], {16'h0, cur});
    op(OP_BLOCK, 2'h3, 0, 0, 2'h0);
    rd(REG_STATUS, 32'hC, 1);
    wr(REG_STATUS, 32'h8);
    setup(9'h005, 9'h003, 16'h00AB, 16'hFFFF);
    op(OP_LOAD_COLOR, 2'h1, 0, 0, 2'h0);
    setup(9'h005, 9'h003, 16'hCD00, 16'hFFFF);
    op(OP_LOAD_COLOR, 2'h2, 0, 0, 2'h0);
    chk(u_dev.color, 16'hCDAB);
    rd(REG_STATUS, 32'h6, 1);
    setup(9'h005, 9'h007, 16'h1111, 16'hFFFF);
    op(OP_BLOCK, 2'h3, 0, 0, 2'h0);
    chk(u_dev.mem[{9'h005, 9'h004}], 16'hCDAB);
    chk(u_dev.mem[{9'h005, 9'h005}], 16'h0000);
    setup(9'h006, 9'h000, 16'hFFFF, 16'hFFFF);
    op(OP_BLOCK, 2'h3, 0, 1, 2'h0);
    chk(u_dev.mem[{9'h006, 9'h002}], 16'h0D0B);
    for (int i = 0; i < 3; i++) begin
      r0 = u_dev.ref_row;
      op(OP_CBR, 2'h3, 0, 0, kinds[i]);
      chk(u_dev.ref_row, r0 + 9'h001);
      chk(u_dev.persist, kinds[i] != KIND_OPTION_RESET);
    end
    op(OP_CBR, 2'h3, 0, 0, KIND_RESERVED);
    rd(REG_STATUS, 32'hA, 1);
    wr(REG_STATUS, 32'h8);
    r0 = u_dev.ref_row;
    setup(9'h005, 9'h003, 16'h0000, 16'hFFFF);
    op(OP_HIDDEN, 2'h3, 0, 0, 2'h0);
    rd(REG_RDATA, {16'h0, cur}, 1);
    chk(u_dev.ref_row, r0 + 9'h001);
    setup(9'h1A5, 9'h000, 16'h0000, 16'hFFFF);
    op(OP_RAS_ONLY, 2'h3, 0, 0, 2'h0);
    chk(u_dev.ras_row, 9'h1A5);
    r0 = u_dev.ref_row;
    wr(REG_REFCTL, 32'h1);
    repeat (130) @(posedge sys_clk_in);
    wr(REG_REFCTL, 32'h0);
    wait_idle();
    chk(u_dev.ref_row - r0 >= 2 && u_dev.ref_row - r0 <= 4, 1);
    chk(u_dev.bad_oe, 0);
    stop_test();
  end
endmodule
`default_nettype wire
